// ### rtl/cmd_escape_pkg.sv
// Constants, codes and state encodings of the command escape and diagnostics block.
// Assumes one 200 MHz system clock and a serial byte stream already deframed upstream.
package cmd_escape_pkg;

    localparam int CLK_PERIOD_NS = 5;
    localparam int MS_UNIT_NS = 1000000;
    localparam int MS_CYCLES = (MS_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IDLE_UNIT_MS = 100;
    localparam logic [6:0] IDLE_SUB_LAST = 7'(IDLE_UNIT_MS - 1);

    localparam logic [15:0] TIMEOUT_RST = 16'h0064;
    localparam logic [15:0] TIMEOUT_MIN = 16'h0002;
    localparam logic [15:0] TIMEOUT_MAX = 16'h028f;
    localparam logic [15:0] GUARD_RST = 16'h03e8;
    localparam logic [15:0] GUARD_MIN = 16'h0001;
    localparam logic [15:0] GUARD_MAX = 16'h0ce4;
    localparam logic [7:0] ESC_CHAR_RST = 8'h2b;
    localparam logic [1:0] ESC_CHAR_COUNT = 2'h3;

    // Identity defaults are arbitrary values.
    localparam logic [11:0] FW_MAIN_RELEASE_DEF = 12'h4c3;
    localparam logic [3:0] FW_REVISION_DEF = 4'h7;
    localparam logic [7:0] HW_MODULE_TYPE_DEF = 8'h5e;
    localparam logic [7:0] HW_REVISION_DEF = 8'h03;

    localparam logic [7:0] JOIN_OK = 8'h00;
    localparam logic [7:0] JOIN_NO_PANS = 8'h21;
    localparam logic [7:0] JOIN_NO_VALID_PANS = 8'h22;
    localparam logic [7:0] JOIN_NOT_PERMITTED = 8'h23;
    localparam logic [7:0] JOIN_NO_BEACONS = 8'h24;
    localparam logic [7:0] JOIN_UNEXPECTED = 8'h25;
    localparam logic [7:0] JOIN_ATTEMPT_FAIL = 8'h27;
    localparam logic [7:0] JOIN_START_FAIL = 8'h2a;
    localparam logic [7:0] JOIN_CHECKING = 8'h2b;
    localparam logic [7:0] JOIN_LEAVE_FAIL = 8'h2c;
    localparam logic [7:0] JOIN_NO_RESPONSE = 8'hab;
    localparam logic [7:0] JOIN_KEY_UNSECURED = 8'hac;
    localparam logic [7:0] JOIN_BAD_LINK_KEY = 8'had;
    localparam logic [7:0] JOIN_SCANNING = 8'hff;
    localparam logic [7:0] JOIN_RST = JOIN_SCANNING;

    typedef enum logic [2:0] {
        CMD_FIRMWARE = 3'h0,
        CMD_HARDWARE = 3'h1,
        CMD_JOIN = 3'h2,
        CMD_TIMEOUT = 3'h3,
        CMD_GUARD = 3'h4,
        CMD_ESCAPE = 3'h5,
        CMD_LEAVE = 3'h6,
        CMD_APPLY = 3'h7
    } cmd_code_e;

    typedef enum logic [3:0] {
        SEQ_WAIT = 4'b0001,
        SEQ_CHARS = 4'b0010,
        SEQ_POST = 4'b0100,
        SEQ_CMD = 4'b1000
    } seq_state_e;

endpackage : cmd_escape_pkg

// ### rtl/ms_tick_gen.sv
// Millisecond tick generator with a restart input.
// Assumes the caller gives the tick length in system clock cycles.
`timescale 1ns/1ps
module ms_tick_gen #(
    parameter int TICK_CYCLES = cmd_escape_pkg::MS_CYCLES
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic restart,
    output logic tick
);

    logic [31:0] countFF;
    logic atLast;

    assign atLast = (countFF == 32'(TICK_CYCLES - 1));
    assign tick = ce && !restart && atLast;

    // A restart realigns the tick phase to the event that caused it.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            countFF <= 32'h0;
        end else if (ce) begin
            if (restart || atLast) begin
                countFF <= 32'h0;
            end else begin
                countFF <= countFF + 32'h1;
            end
        end
    end

endmodule : ms_tick_gen

// ### rtl/command_escape_and_diagnostics.sv
// Escape sequence detector, command state timer and diagnostic words of the serial interface.
// Assumes an upstream receiver gives one byte per rxValid pulse and an upstream parser
// turns command text into one cmdValid request, answered one cycle later.
`timescale 1ns/1ps
module command_escape_and_diagnostics #(
    parameter int MS_CYCLES = cmd_escape_pkg::MS_CYCLES,
    parameter logic [11:0] FW_MAIN_RELEASE = cmd_escape_pkg::FW_MAIN_RELEASE_DEF,
    parameter logic [3:0] FW_REVISION = cmd_escape_pkg::FW_REVISION_DEF,
    parameter logic [7:0] HW_MODULE_TYPE = cmd_escape_pkg::HW_MODULE_TYPE_DEF,
    parameter logic [7:0] HW_REVISION = cmd_escape_pkg::HW_REVISION_DEF
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic framedMode,
    input wire logic rxValid,
    input wire logic [7:0] rxData,
    output logic passValid,
    output logic [7:0] passData,
    input wire logic cmdValid,
    input wire logic [2:0] cmdCode,
    input wire logic cmdWrite,
    input wire logic [15:0] cmdWdata,
    output logic rspValid,
    output logic [15:0] rspData,
    output logic rspError,
    output logic commandState,
    output logic applyPulse,
    input wire logic joinLoad,
    input wire logic [7:0] joinCode,
    output logic [7:0] joinStatus,
    output logic joined
);

    function automatic logic in_range(input logic [15:0] val, input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (val >= lo) && (val <= hi);
    endfunction : in_range

    cmd_escape_pkg::seq_state_e seqFF;
    logic [1:0] escCountFF;
    logic [15:0] silenceMsFF;
    logic [6:0] idleSubFF;
    logic [15:0] idleUnitsFF;
    logic [15:0] timeoutActiveFF;
    logic [15:0] timeoutPendingFF;
    logic [15:0] guardActiveFF;
    logic [15:0] guardPendingFF;
    logic [7:0] escActiveFF;
    logic [7:0] escPendingFF;
    logic [7:0] joinStatusFF;
    logic joinedFF;
    logic passValidFF;
    logic [7:0] passDataFF;
    logic rspValidFF;
    logic [15:0] rspDataFF;
    logic rspErrorFF;
    logic applyFF;

    logic msTick;
    logic inCmd;
    logic guardMet;
    logic isEsc;
    logic timeoutHit;
    logic cmdErr;
    logic [15:0] cmdRdata;
    logic cmdAccept;
    logic leaveAccept;
    logic applyAccept;
    logic [15:0] firmwareWord;
    logic [15:0] hardwareWord;

    assign firmwareWord = {FW_MAIN_RELEASE, FW_REVISION};
    assign hardwareWord = {HW_MODULE_TYPE, HW_REVISION};
    assign inCmd = (seqFF == cmd_escape_pkg::SEQ_CMD);
    assign guardMet = (silenceMsFF >= guardActiveFF);
    assign isEsc = (rxData == escActiveFF);
    assign timeoutHit = (idleUnitsFF >= timeoutActiveFF);
    assign cmdAccept = cmdValid && !cmdErr;
    assign leaveAccept = cmdAccept && (cmdCode == cmd_escape_pkg::CMD_LEAVE);
    assign applyAccept = cmdAccept && (cmdCode == cmd_escape_pkg::CMD_APPLY);

    ms_tick_gen #(
        .TICK_CYCLES(MS_CYCLES)
    ) u_tick (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .restart(rxValid || cmdAccept),
        .tick(msTick)
    );

    // Command decode; every command is refused outside command state.
    always_comb begin
        cmdErr = 1'b0;
        cmdRdata = 16'h0000;
        unique case (cmdCode)
            cmd_escape_pkg::CMD_FIRMWARE: begin
                cmdRdata = firmwareWord;
                cmdErr = cmdWrite;
            end
            cmd_escape_pkg::CMD_HARDWARE: begin
                cmdRdata = hardwareWord;
                cmdErr = cmdWrite;
            end
            cmd_escape_pkg::CMD_JOIN: begin
                cmdRdata = {8'h00, joinStatusFF};
                cmdErr = cmdWrite;
            end
            cmd_escape_pkg::CMD_TIMEOUT: begin
                cmdRdata = timeoutPendingFF;
                cmdErr = cmdWrite && !in_range(cmdWdata, cmd_escape_pkg::TIMEOUT_MIN,
                                               cmd_escape_pkg::TIMEOUT_MAX);
            end
            cmd_escape_pkg::CMD_GUARD: begin
                cmdRdata = guardPendingFF;
                cmdErr = cmdWrite && !in_range(cmdWdata, cmd_escape_pkg::GUARD_MIN,
                                               cmd_escape_pkg::GUARD_MAX);
            end
            cmd_escape_pkg::CMD_ESCAPE: begin
                cmdRdata = {8'h00, escPendingFF};
                cmdErr = framedMode || (cmdWrite && (cmdWdata[15:8] != 8'h00));
            end
            cmd_escape_pkg::CMD_LEAVE: begin
                cmdRdata = 16'h0000;
            end
            cmd_escape_pkg::CMD_APPLY: begin
                cmdRdata = 16'h0000;
            end
        endcase
        if (!inCmd) begin
            cmdErr = 1'b1;
        end
    end

    // Escape sequence detection and command state.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            seqFF <= cmd_escape_pkg::SEQ_WAIT;
            escCountFF <= 2'h0;
        end else if (ce) begin
            unique case (seqFF)
                cmd_escape_pkg::SEQ_WAIT: begin
                    if (rxValid && !framedMode && isEsc && guardMet) begin
                        seqFF <= cmd_escape_pkg::SEQ_CHARS;
                        escCountFF <= 2'h1;
                    end
                end
                cmd_escape_pkg::SEQ_CHARS: begin
                    if (framedMode) begin
                        seqFF <= cmd_escape_pkg::SEQ_WAIT;
                    end else if (rxValid && isEsc) begin
                        escCountFF <= escCountFF + 2'h1;
                        if (escCountFF == cmd_escape_pkg::ESC_CHAR_COUNT - 2'h1) begin
                            seqFF <= cmd_escape_pkg::SEQ_POST;
                        end
                    end else if (rxValid) begin
                        seqFF <= cmd_escape_pkg::SEQ_WAIT;
                    end
                end
                cmd_escape_pkg::SEQ_POST: begin
                    if (rxValid || framedMode) begin
                        seqFF <= cmd_escape_pkg::SEQ_WAIT;
                    end else if (guardMet) begin
                        seqFF <= cmd_escape_pkg::SEQ_CMD;
                    end
                end
                cmd_escape_pkg::SEQ_CMD: begin
                    if (leaveAccept || timeoutHit) begin
                        seqFF <= cmd_escape_pkg::SEQ_WAIT;
                    end
                end
            endcase
        end
    end

    // Silence since the last received byte, in milliseconds, saturating.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            silenceMsFF <= 16'h0000;
        end else if (ce) begin
            if (rxValid) begin
                silenceMsFF <= 16'h0000;
            end else if (msTick && (silenceMsFF != 16'hffff)) begin
                silenceMsFF <= silenceMsFF + 16'h0001;
            end
        end
    end

    // Inactivity in 100 ms units; a valid command or leaving restarts it.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            idleSubFF <= 7'h00;
            idleUnitsFF <= 16'h0000;
        end else if (ce) begin
            if (!inCmd || cmdAccept) begin
                idleSubFF <= 7'h00;
                idleUnitsFF <= 16'h0000;
            end else if (msTick) begin
                if (idleSubFF == cmd_escape_pkg::IDLE_SUB_LAST) begin
                    idleSubFF <= 7'h00;
                    if (idleUnitsFF != 16'hffff) begin
                        idleUnitsFF <= idleUnitsFF + 16'h0001;
                    end
                end else begin
                    idleSubFF <= idleSubFF + 7'h01;
                end
            end
        end
    end

    // Queued settings; writes land in the pending copy, leave or apply moves them over.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            timeoutPendingFF <= cmd_escape_pkg::TIMEOUT_RST;
            guardPendingFF <= cmd_escape_pkg::GUARD_RST;
            escPendingFF <= cmd_escape_pkg::ESC_CHAR_RST;
            timeoutActiveFF <= cmd_escape_pkg::TIMEOUT_RST;
            guardActiveFF <= cmd_escape_pkg::GUARD_RST;
            escActiveFF <= cmd_escape_pkg::ESC_CHAR_RST;
            applyFF <= 1'b0;
        end else if (ce) begin
            applyFF <= leaveAccept || applyAccept;
            if (cmdAccept && cmdWrite) begin
                if (cmdCode == cmd_escape_pkg::CMD_TIMEOUT) begin
                    timeoutPendingFF <= cmdWdata;
                end
                if (cmdCode == cmd_escape_pkg::CMD_GUARD) begin
                    guardPendingFF <= cmdWdata;
                end
                if (cmdCode == cmd_escape_pkg::CMD_ESCAPE) begin
                    escPendingFF <= cmdWdata[7:0];
                end
            end
            if (leaveAccept || applyAccept) begin
                timeoutActiveFF <= timeoutPendingFF;
                guardActiveFF <= guardPendingFF;
                escActiveFF <= escPendingFF;
            end
        end
    end

    // Answer to each command, one cycle after it.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rspValidFF <= 1'b0;
            rspDataFF <= 16'h0000;
            rspErrorFF <= 1'b0;
        end else if (ce) begin
            rspValidFF <= cmdValid;
            if (cmdValid) begin
                rspDataFF <= cmdErr ? 16'h0000 : cmdRdata;
                rspErrorFF <= cmdErr;
            end
        end
    end

    // Join status is loaded by the network logic; unknown future codes are kept as given.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            joinStatusFF <= cmd_escape_pkg::JOIN_RST;
            joinedFF <= 1'b0;
        end else if (ce && joinLoad) begin
            joinStatusFF <= joinCode;
            joinedFF <= (joinCode == cmd_escape_pkg::JOIN_OK);
        end
    end

    // Bytes outside command state go on as ordinary traffic.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            passValidFF <= 1'b0;
            passDataFF <= 8'h00;
        end else if (ce) begin
            passValidFF <= rxValid && !inCmd;
            if (rxValid) begin
                passDataFF <= rxData;
            end
        end
    end

    assign passValid = passValidFF;
    assign passData = passDataFF;
    assign rspValid = rspValidFF;
    assign rspData = rspDataFF;
    assign rspError = rspErrorFF;
    assign commandState = inCmd;
    assign applyPulse = applyFF;
    assign joinStatus = joinStatusFF;
    assign joined = joinedFF;

    a_fw_read_word: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && cmdValid && inCmd && !cmdWrite && cmdCode == cmd_escape_pkg::CMD_FIRMWARE)
        |=> rspValid && !rspError && rspData == {FW_MAIN_RELEASE, FW_REVISION})
        else $error("firmware word answer wrong");

    a_hw_read_word: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && cmdValid && inCmd && !cmdWrite && cmdCode == cmd_escape_pkg::CMD_HARDWARE)
        |=> rspValid && rspData[15:8] == HW_MODULE_TYPE && rspData[7:0] == HW_REVISION)
        else $error("hardware word answer wrong");

    a_join_flag_match: assert property (@(posedge clk_sys) disable iff (!resetn)
        joined == (joinStatus == cmd_escape_pkg::JOIN_OK))
        else $error("joined flag disagrees with join status");

    a_join_code_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && joinLoad) |=> joinStatus == $past(joinCode))
        else $error("join status did not take the reported code");

    a_idle_timeout_exit: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && inCmd && !cmdAccept && idleUnitsFF >= timeoutActiveFF) |=> !commandState)
        else $error("command state outlived its timeout");

    a_timeout_range_chk: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && cmdValid && inCmd && cmdWrite && cmdCode == cmd_escape_pkg::CMD_TIMEOUT &&
         (cmdWdata < 16'h0002 || cmdWdata > 16'h028f)) |=> rspError && $stable(timeoutPendingFF))
        else $error("out of range timeout accepted");

    a_leave_applies: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && inCmd && cmdValid && !cmdWrite && cmdCode == cmd_escape_pkg::CMD_LEAVE)
        |=> !commandState && applyPulse && timeoutActiveFF == $past(timeoutPendingFF))
        else $error("leave did not exit and apply");

    a_guard_before_esc: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && seqFF == cmd_escape_pkg::SEQ_WAIT && rxValid && silenceMsFF < guardActiveFF)
        |=> seqFF == cmd_escape_pkg::SEQ_WAIT)
        else $error("escape started without guard silence");

    a_sequence_entry: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && seqFF == cmd_escape_pkg::SEQ_POST && !rxValid && !framedMode && guardMet)
        |=> commandState ##1 (commandState || $past(leaveAccept || timeoutHit)))
        else $error("complete escape did not enter command state");

    a_wrong_char_abort: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && seqFF == cmd_escape_pkg::SEQ_CHARS && rxValid && !isEsc)
        |=> seqFF == cmd_escape_pkg::SEQ_WAIT && passValid)
        else $error("wrong character did not abort escape");

    a_framed_no_esc: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && cmdValid && framedMode && cmdCode == cmd_escape_pkg::CMD_ESCAPE) |=> rspError)
        else $error("escape character offered in framed mode");

    a_ro_write_error: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && cmdValid && cmdWrite && cmdCode == cmd_escape_pkg::CMD_JOIN)
        |=> rspError && ($stable(joinStatusFF) || $past(joinLoad)))
        else $error("write to read-only word not refused");

endmodule : command_escape_and_diagnostics

// ### dv/host_model.sv
// Host controller model that sends serial bytes and parsed commands to the block.
// Assumes the bench calls its tasks 1 ns after a rising edge of clk_sys.
`timescale 1ns/1ps
module host_model (
    input wire logic clk_sys,
    output logic rxValid,
    output logic [7:0] rxData,
    output logic cmdValid,
    output logic [2:0] cmdCode,
    output logic cmdWrite,
    output logic [15:0] cmdWdata,
    input wire logic passValid,
    input wire logic rspValid,
    input wire logic [15:0] rspData,
    input wire logic rspError,
    input wire logic applyPulse
);
    initial begin
        rxValid = 1'b0;
        rxData = 8'h00;
        cmdValid = 1'b0;
        cmdCode = 3'h0;
        cmdWrite = 1'b0;
        cmdWdata = 16'h0000;
    end
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : idle
    // A released line shows the inverse of its last value, never a stale copy.
    task automatic send_byte(input logic [7:0] b, output logic p);
        rxValid = 1'b1;
        rxData = b;
        idle(1);
        p = passValid;
        rxValid = 1'b0;
        rxData = ~b;
        idle(1);
    endtask : send_byte
    // The answer comes one edge after the request; a missing answer shows as an unknown error.
    // An idle edge follows, so back-to-back calls never drop and raise the strobe at once.
    task automatic command(input logic [2:0] c, input logic w, input logic [15:0] wd,
                           output logic [15:0] d, output logic e, output logic a);
        cmdValid = 1'b1;
        cmdCode = c;
        cmdWrite = w;
        cmdWdata = wd;
        idle(1);
        cmdValid = 1'b0;
        cmdWdata = ~wd;
        d = rspData;
        e = (rspValid === 1'b1) ? rspError : 1'bx;
        a = applyPulse;
        idle(1);
    endtask : command
    task automatic poll_join(input int maxPolls, output logic [7:0] code);
        logic [15:0] d;
        logic e;
        logic a;
        code = 8'hff;
        for (int i = 0; i < maxPolls && code !== 8'h00; i++) begin
            command(3'h2, 1'b0, 16'h0000, d, e, a);
            code = d[7:0];
        end
    endtask : poll_join
endmodule : host_model

// ### dv/tb_top.sv
// Self-checking bench of the command escape and diagnostics block.
// Assumes host_model beside it and a millisecond shortened to MSC clock cycles.
`timescale 1ns/1ps
module tb_top;
    localparam int MSC = 4;
    localparam logic [15:0] FW = {cmd_escape_pkg::FW_MAIN_RELEASE_DEF,
                                  cmd_escape_pkg::FW_REVISION_DEF};
    localparam logic [15:0] HW = {cmd_escape_pkg::HW_MODULE_TYPE_DEF,
                                  cmd_escape_pkg::HW_REVISION_DEF};
    typedef struct {logic [2:0] c; logic w; logic [15:0] wd; logic [15:0] d; logic [1:0] ea;} row_s;
    // Field ea holds the expected error flag above the expected apply pulse.
    row_s rows [21] = '{
        '{3'h0, 1'b0, 16'h0000, FW, 2'h0}, '{3'h1, 1'b0, 16'h0000, HW, 2'h0},
        '{3'h2, 1'b0, 16'h0000, 16'h00ff, 2'h0}, '{3'h0, 1'b1, 16'h1234, 16'h0000, 2'h2},
        '{3'h1, 1'b1, 16'h1234, 16'h0000, 2'h2}, '{3'h2, 1'b1, 16'h0000, 16'h0000, 2'h2},
        '{3'h0, 1'b0, 16'h0000, FW, 2'h0}, '{3'h3, 1'b0, 16'h0000, 16'h0064, 2'h0},
        '{3'h3, 1'b1, 16'h0001, 16'h0000, 2'h2}, '{3'h3, 1'b1, 16'h0290, 16'h0000, 2'h2},
        '{3'h3, 1'b1, 16'h0002, 16'h0000, 2'h0}, '{3'h3, 1'b0, 16'h0000, 16'h0002, 2'h0},
        '{3'h4, 1'b0, 16'h0000, 16'h03e8, 2'h0}, '{3'h4, 1'b1, 16'h0000, 16'h0000, 2'h2},
        '{3'h4, 1'b1, 16'h0ce5, 16'h0000, 2'h2}, '{3'h4, 1'b1, 16'h0001, 16'h0000, 2'h0},
        '{3'h5, 1'b0, 16'h0000, 16'h002b, 2'h0}, '{3'h5, 1'b1, 16'h0100, 16'h0000, 2'h2},
        '{3'h5, 1'b1, 16'h002a, 16'h0000, 2'h0}, '{3'h5, 1'b0, 16'h0000, 16'h002a, 2'h0},
        '{3'h7, 1'b1, 16'h0000, 16'h0000, 2'h1}};
    logic [31:0] bseq [4] = '{32'h00412a2a, 32'h422a2a2a, 32'h002b2b2b, 32'h002a2a2a};
    int bn [4] = '{3, 4, 3, 3};
    logic bexp [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    logic [7:0] codes [14] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h27, 8'h2a, 8'h2b,
                               8'h2c, 8'hab, 8'hac, 8'had, 8'hff, 8'h00};
    logic clk_sys, resetn, ce, framedMode, rxValid, passValid, cmdValid, cmdWrite;
    logic rspValid, rspError, commandState, applyPulse, joinLoad, joined, e, a, p;
    logic [7:0] rxData, passData, joinCode, joinStatus, code;
    logic [2:0] cmdCode;
    logic [15:0] cmdWdata, rspData, d;
    int num_errors = 0;
    int comparisons = 0;

    command_escape_and_diagnostics #(.MS_CYCLES(MSC)) dut_u (
        .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .framedMode(framedMode),
        .rxValid(rxValid), .rxData(rxData), .passValid(passValid), .passData(passData),
        .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdWrite(cmdWrite), .cmdWdata(cmdWdata),
        .rspValid(rspValid), .rspData(rspData), .rspError(rspError),
        .commandState(commandState), .applyPulse(applyPulse), .joinLoad(joinLoad),
        .joinCode(joinCode), .joinStatus(joinStatus), .joined(joined));
    host_model host_u (
        .clk_sys(clk_sys), .rxValid(rxValid), .rxData(rxData), .cmdValid(cmdValid),
        .cmdCode(cmdCode), .cmdWrite(cmdWrite), .cmdWdata(cmdWdata), .passValid(passValid),
        .rspValid(rspValid), .rspData(rspData), .rspError(rspError), .applyPulse(applyPulse));

    task automatic check(input string n, input logic [15:0] s, input logic [15:0] x);
        comparisons++;
        if (s !== x) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, x, s);
        end
    endtask : check
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (40000) @(posedge clk_sys);
        num_errors++;
        give_verdict();
    end
    initial begin
        ce = 1'b1;
        framedMode = 1'b0;
        joinLoad = 1'b0;
        joinCode = 8'h00;
        resetn = 1'b0;
        host_u.idle(2);
        resetn = 1'b1;
        check("commandState", commandState, 1'b0);
        check("joinStatus", joinStatus, 8'hff);
        check("joined", joined, 1'b0);
        $display("reset test done");
        host_u.command(3'h0, 1'b0, 16'h0000, d, e, a);
        check("idle refusal", e, 1'b1);
        host_u.send_byte(8'h41, p);
        check("passValid", p, 1'b1);
        check("passData", passData, 8'h41);
        host_u.idle(1000 * MSC + 100);
        for (int k = 0; k < 3; k++) host_u.send_byte(8'h2b, p);
        host_u.idle(1000 * MSC - 100);
        check("early entry", commandState, 1'b0);
        host_u.idle(200);
        check("entry", commandState, 1'b1);
        $display("escape test done");
        for (int i = 0; i < 21; i++) begin
            host_u.command(rows[i].c, rows[i].w, rows[i].wd, d, e, a);
            check($sformatf("row %0d flags", i), {e, a}, rows[i].ea);
            if (!rows[i].w || rows[i].ea[1])
                check($sformatf("row %0d data", i), d, rows[i].d);
        end
        host_u.send_byte(8'h43, p);
        check("held byte", p, 1'b0);
        host_u.idle(760);
        check("before timeout", commandState, 1'b1);
        host_u.idle(90);
        check("after timeout", commandState, 1'b0);
        $display("register table test done");
        for (int i = 0; i < 4; i++) begin
            host_u.idle(10);
            for (int k = 0; k < bn[i]; k++) host_u.send_byte(bseq[i][8*k+:8], p);
            host_u.idle(20);
            check($sformatf("escape case %0d", i), commandState, bexp[i]);
        end
        $display("escape abort test done");
        foreach (codes[i]) begin
            joinCode = codes[i];
            joinLoad = 1'b1;
            host_u.idle(1);
            joinLoad = 1'b0;
            check("joinStatus", joinStatus, codes[i]);
            check("joined", joined, codes[i] == 8'h00);
            host_u.command(3'h2, 1'b0, 16'h0000, d, e, a);
            check("join read", d, {8'h00, codes[i]});
        end
        host_u.poll_join(4, code);
        check("poll", code, 8'h00);
        joinCode = 8'h2b;
        joinLoad = 1'b1;
        ce = 1'b0;
        host_u.idle(1);
        check("frozen join", joinStatus, 8'h00);
        ce = 1'b1;
        host_u.idle(1);
        joinLoad = 1'b0;
        check("thawed join", joinStatus, 8'h2b);
        $display("join status test done");
        framedMode = 1'b1;
        host_u.command(3'h5, 1'b0, 16'h0000, d, e, a);
        check("framed escape", e, 1'b1);
        framedMode = 1'b0;
        host_u.command(3'h3, 1'b1, 16'h028f, d, e, a);
        check("timeout max", e, 1'b0);
        host_u.command(3'h6, 1'b0, 16'h0000, d, e, a);
        check("leave apply", a, 1'b1);
        check("leave", commandState, 1'b0);
        $display("leave test done");
        give_verdict();
    end
endmodule : tb_top
